// ### dv/ctlp_chk_asserts.sv
// Port-level assertions for the calibration trigger and low-power control block
`timescale 1ns/1ns
module ctlp_chk (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Register bus handshakes
  input wire s_axi_awvalid_in,
  input wire s_axi_awready_out,
  input wire s_axi_wvalid_in,
  input wire s_axi_wready_out,
  input wire [1:0] s_axi_bresp_out,
  input wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  input wire s_axi_arvalid_in,
  input wire s_axi_arready_out,
  input wire [31:0] s_axi_rdata_out,
  input wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Scheduler outputs
  input wire adc_wake_out,
  input wire cal_start_out,
  input wire lp_active_out,
  input wire background_cal_enable_out
);
  // ==================================================================
  // Single clock domain
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);

  // ==================================================================
  // Bus handshakes
  chk_wr_answer: assert property (s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in
    && s_axi_wready_out |-> ##[1:2] s_axi_bvalid_out) else $error("Write answer late");
  chk_b_hold: assert property (s_axi_bvalid_out && !s_axi_bready_in
    |=> s_axi_bvalid_out && $stable(s_axi_bresp_out)) else $error("Write answer dropped");
  chk_rd_answer: assert property (s_axi_arvalid_in && s_axi_arready_out
    |=> s_axi_rvalid_out && !s_axi_arready_out) else $error("Read answer late");
  chk_r_hold: assert property (s_axi_rvalid_out && !s_axi_rready_in
    |=> s_axi_rvalid_out && $stable(s_axi_rdata_out)) else $error("Read answer dropped");

  // ==================================================================
  // Scheduler
  chk_start_pulse: assert property (cal_start_out |=> !cal_start_out)
    else $error("Calibration start not a single pulse");
  chk_start_awake: assert property (cal_start_out |-> adc_wake_out && lp_active_out)
    else $error("Calibration started on a sleeping converter");
  chk_off_awake: assert property (!lp_active_out |-> adc_wake_out)
    else $error("Converter asleep with low power off");
  chk_sleep_entry: assert property ($rose(lp_active_out) |-> !adc_wake_out)
    else $error("No sleep on low power entry");
  chk_bg_needed: assert property ($fell(background_cal_enable_out) |-> ##[0:2] !lp_active_out)
    else $error("Low power kept without background calibration");

  // Main scenarios reached
  cover property (cal_start_out);
  cover property (lp_active_out && $rose(adc_wake_out));
  cover property (s_axi_bvalid_out && s_axi_bresp_out == 2'h2);
endmodule

bind ctlp_top ctlp_chk u_chk (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awready_out(s_axi_awready_out),
  .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_wready_out(s_axi_wready_out),
  .s_axi_bresp_out(s_axi_bresp_out), .s_axi_bvalid_out(s_axi_bvalid_out),
  .s_axi_bready_in(s_axi_bready_in), .s_axi_arvalid_in(s_axi_arvalid_in),
  .s_axi_arready_out(s_axi_arready_out), .s_axi_rdata_out(s_axi_rdata_out),
  .s_axi_rvalid_out(s_axi_rvalid_out), .s_axi_rready_in(s_axi_rready_in),
  .adc_wake_out(adc_wake_out), .cal_start_out(cal_start_out),
  .lp_active_out(lp_active_out), .background_cal_enable_out(background_cal_enable_out)
);

// ### dv/ctlp_top_tb.sv
// Self-checking bench for the calibration trigger and low-power control block
`timescale 1ns/1ns
`include "ctlp_consts.vh"
module ctlp_top_tb;
  // ==================================================================
  // Signals and table
  localparam int T = 2;
  logic clk, rst_n, awv, wv, bry, arv, rry, pin_lvl, done, slow;
  logic [11:0] awa, ara;
  logic [31:0] wd, v;
  logic [1:0] rsp;
  wire awr, wr, bv, arr, rv, trig, wake, start, lpa, bge, vee, pin;
  wire [1:0] bre, rre;
  wire [31:0] rd;
  int n_fail, checked;
  typedef struct {logic [11:0] a; logic [7:0] d; logic [7:0] e; logic [1:0] r;} ctlp_row_t;
  ctlp_row_t rows [5] = '{
    '{`CTLP_ADDR_SOFT_TRIG, 8'hA5, 8'hA5, `CTLP_RESP_OKAY},
    '{`CTLP_ADDR_LP_CFG, 8'h5A, 8'h5A, `CTLP_RESP_OKAY},
    '{`CTLP_ADDR_PIN_CFG, 8'hF6, 8'hF6, `CTLP_RESP_OKAY},
    '{`CTLP_ADDR_VEC_EN, 8'h01, 8'h01, `CTLP_RESP_OKAY},
    '{12'h1D0, 8'hFF, 8'h00, `CTLP_RESP_SLVERR}};

  ctlp_top #(.TICK_CYCLES(T), .EXP_REDUCE(6'h14)) DUT (
    .core_clk_in(clk), .rst_n_in(rst_n), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
    .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF),
    .s_axi_wvalid_in(wv), .s_axi_wready_out(wr), .s_axi_bresp_out(bre),
    .s_axi_bvalid_out(bv), .s_axi_bready_in(bry), .s_axi_araddr_in(ara),
    .s_axi_arvalid_in(arv), .s_axi_arready_out(arr), .s_axi_rdata_out(rd),
    .s_axi_rresp_out(rre), .s_axi_rvalid_out(rv), .s_axi_rready_in(rry),
    .cal_trigger_pin_in(pin), .cal_done_in(done), .cal_trigger_out(trig),
    .adc_wake_out(wake), .cal_start_out(start), .lp_active_out(lpa),
    .background_cal_enable_out(bge), .cal_vector_enable_out(vee));
  ctlp_trig_src u_src (.core_clk_in(clk), .level_in(pin_lvl), .pin_out(pin));

  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #60000;
    n_fail++;
    end_sim();
  end

  // ==================================================================
  // Tasks
  task end_sim();
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, e);
    end
  endtask
  task wr_reg(input logic [11:0] a, input logic [7:0] d);
    int k;
    k = 0;
    awa <= a;
    wd <= {24'h000000, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= !slow;
    do begin
      @(posedge clk);
      k++;
      if (awv && awr) awv <= 1'b0;
      if (wv && wr) wv <= 1'b0;
      if (bv && !bry) bry <= 1'b1;
    end while (!(bv && bry) && k < 50);
    chk(k < 50, 1);
    rsp = bre;
    bry <= 1'b0;
    @(posedge clk);
  endtask
  task rd_chk(input logic [11:0] a, input logic [7:0] e, input logic [1:0] r);
    int k;
    k = 0;
    ara <= a;
    arv <= 1'b1;
    rry <= !slow;
    do begin
      @(posedge clk);
      k++;
      if (arv && arr) arv <= 1'b0;
      if (rv && !rry) rry <= 1'b1;
    end while (!(rv && rry) && k < 50);
    chk(k < 50, 1);
    v = rd;
    chk(rre, r);
    rry <= 1'b0;
    @(posedge clk);
    chk(v, {24'h000000, e});
  endtask
  task cal_run(input int tw);
    int k;
    k = 0;
    while (start !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk(k >= tw - 6 && k <= tw + 4, 1);
    done <= 1'b1;
    @(posedge clk);
    done <= 1'b0;
    @(posedge clk);
    chk(wake, 1'b0);
  endtask
  task lp_auto(input logic [7:0] cfg, input int ts, input int tw);
    int k;
    k = 0;
    wr_reg(`CTLP_ADDR_LP_CFG, cfg);
    wr_reg(`CTLP_ADDR_PIN_CFG, 8'h08);
    chk({bge, wake}, 2'b10);
    while (wake !== 1'b1 && k < 300) begin
      @(posedge clk);
      k++;
    end
    chk(k >= ts - 6 && k <= ts + 4, 1);
    cal_run(tw);
    wr_reg(`CTLP_ADDR_PIN_CFG, 8'h00);
    chk({bge, lpa, wake}, 3'b001);
  endtask

  // ==================================================================
  // Main sequence
  initial begin
    {rst_n, awv, wv, bry, arv, rry, done, slow, awa, ara, wd} = '0;
    pin_lvl = 1'b1;
    repeat (20) @(posedge clk);
    chk({trig, wake, lpa, vee}, 4'hC);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`CTLP_ADDR_SOFT_TRIG, 8'h01, `CTLP_RESP_OKAY);
    rd_chk(`CTLP_ADDR_LP_CFG, 8'h88, `CTLP_RESP_OKAY);
    rd_chk(`CTLP_ADDR_VEC_EN, 8'h00, `CTLP_RESP_OKAY);
    foreach (rows[i]) begin
      wr_reg(rows[i].a, rows[i].d);
      chk(rsp, rows[i].r);
      rd_chk(rows[i].a, rows[i].e, rows[i].r);
    end
    // Late bready and rready from here on
    slow = 1'b1;
    chk(vee, 1'b1);
    wr_reg(`CTLP_ADDR_VEC_EN, 8'h00);
    chk(vee, 1'b0);
    wr_reg(`CTLP_ADDR_PIN_CFG, 8'h00);
    // Trigger source selection
    wr_reg(`CTLP_ADDR_SOFT_TRIG, 8'h00);
    repeat (4) @(posedge clk);
    chk(trig, 1'b0);
    wr_reg(`CTLP_ADDR_PIN_CFG, 8'h01);
    repeat (4) @(posedge clk);
    chk(trig, 1'b1);
    pin_lvl <= 1'b0;
    repeat (3) @(posedge clk);
    chk(trig, 1'b1);
    repeat (4) @(posedge clk);
    chk(trig, 1'b0);
    wr_reg(`CTLP_ADDR_SOFT_TRIG, 8'h01);
    repeat (2) @(posedge clk);
    chk(trig, 1'b0);
    wr_reg(`CTLP_ADDR_PIN_CFG, 8'h00);
    repeat (2) @(posedge clk);
    chk(trig, 1'b1);
    // Low power needs background calibration
    wr_reg(`CTLP_ADDR_LP_CFG, 8'h89);
    repeat (4) @(posedge clk);
    chk({lpa, wake}, 2'b01);
    // Autonomous sleep and settle: codes 5/1, then 4/3
    // sleep codes four up, wake codes one up
    lp_auto(8'hA9, ((1 << 7) + 1) * T, 2 * T);
    lp_auto(8'h99, ((1 << 4) + 1) * T, ((1 << 4) + 1) * T);
    // Triggered wake from the software trigger
    wr_reg(`CTLP_ADDR_LP_CFG, 8'h8B);
    wr_reg(`CTLP_ADDR_PIN_CFG, 8'h08);
    repeat (40) @(posedge clk);
    chk(wake, 1'b0);
    wr_reg(`CTLP_ADDR_SOFT_TRIG, 8'h00);
    cal_run(2 * T);
    // Reset in mid-run
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(`CTLP_ADDR_LP_CFG, 8'h88, `CTLP_RESP_OKAY);
    rd_chk(`CTLP_ADDR_SOFT_TRIG, 8'h01, `CTLP_RESP_OKAY);
    end_sim();
  end
endmodule

// ### dv/ctlp_trig_src.sv
// External trigger source model driving the calibration trigger pin
`timescale 1ns/1ns
module ctlp_trig_src (
  // Clock
  input wire core_clk_in,
  // Level asked for by the bench
  input wire level_in,
  // Trigger pin
  output reg pin_out
);
  // ==================================================================
  // Pin moves just after an edge, idle high
  initial pin_out = 1'b1;
  always @(posedge core_clk_in) begin
    pin_out <= level_in;
  end
endmodule

// ### hdl/ctlp_delay_timer.v
// Delay timer counting (2^k + 1) ticks of TICK_CYCLES clocks each
`timescale 1ns/1ns
module ctlp_delay_timer #(
  parameter TICK_CYCLES = 256
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // Control
  input wire start_in,
  input wire abort_in,
  input wire [5:0] exp_in,
  // Status
  output reg busy_out,
  output reg done_out
);

  localparam [31:0] TICK_M1 = TICK_CYCLES - 1;
  localparam [15:0] PRE_LAST = TICK_M1[15:0];

  reg [15:0] pre_r;
  reg [34:0] cnt_r;
  reg [34:0] last_r;

  // =====================================================================
  // Prescaler and tick counter; a new start restarts the count unless abort_in is high in the same cycle
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pre_r <= 16'h0000;
      cnt_r <= 35'h000000000;
      last_r <= 35'h000000000;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        busy_out <= 1'b0;
      end else if (start_in) begin
        busy_out <= 1'b1;
        pre_r <= 16'h0000;
        cnt_r <= 35'h000000000;
        last_r <= 35'h000000001 << exp_in; // 2^k + 1 ticks, last index 2^k
      end else if (busy_out) begin
        if (pre_r == PRE_LAST) begin
          pre_r <= 16'h0000;
          if (cnt_r == last_r) begin
            busy_out <= 1'b0;
            done_out <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 35'h000000001;
          end
        end else begin
          pre_r <= pre_r + 16'h0001;
        end
      end
    end
  end

endmodule

// ### hdl/ctlp_top.v
// Calibration trigger select and low-power calibration sleep/wake control
// How it works
// R01: trigger select clear: calibration trigger follows the software trigger bit
// R02: trigger select set: trigger follows the external pin, software bit ignored
// R03: no triggering needed: keep select clear and software bit at one
// R04: sleep code bits 7:5 give idle (2^k+1)x256 clocks, k from table
// R05: software should not program sleep codes below four
// R06: wake code bits 4:3 give settle (2^k+1)x256 clocks before calibrating
// R07: software should not program wake code zero
// R08: triggered-wake clear: sleep time comes from sleep code, autonomous
// R09: triggered-wake set: ADC sleeps until the selected trigger goes low
// R10: low-power scheme active only with its enable and background calibration on
// R11: low-power configuration register resets to 0x88
// R12: software trigger register resets to 0x01
// R13: vector access enable bit 0 opens the calibration vector port, reset zero
// R14: software must access the vector port exactly 673 times
// R15: external trigger pin is synchronised before use
`timescale 1ns/1ns
`include "ctlp_consts.vh"
module ctlp_top #(
  parameter TICK_CYCLES = `CTLP_TICK_CYCLES,
  parameter [5:0] EXP_REDUCE = 6'h00
) (
  // Clock and reset
  input wire core_clk_in,
  input wire rst_n_in,
  // AXI4-Lite write address and data
  input wire [11:0] s_axi_awaddr_in,
  input wire s_axi_awvalid_in,
  output reg s_axi_awready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  input wire s_axi_wvalid_in,
  output reg s_axi_wready_out,
  // AXI4-Lite write response
  output reg [1:0] s_axi_bresp_out,
  output reg s_axi_bvalid_out,
  input wire s_axi_bready_in,
  // AXI4-Lite read
  input wire [11:0] s_axi_araddr_in,
  input wire s_axi_arvalid_in,
  output reg s_axi_arready_out,
  output reg [31:0] s_axi_rdata_out,
  output reg [1:0] s_axi_rresp_out,
  output reg s_axi_rvalid_out,
  input wire s_axi_rready_in,
  // Trigger pin and calibration engine
  input wire cal_trigger_pin_in,
  input wire cal_done_in,
  // Control outputs
  output reg cal_trigger_out,
  output reg adc_wake_out,
  output reg cal_start_out,
  output reg lp_active_out,
  output reg background_cal_enable_out,
  output reg cal_vector_enable_out
);

  localparam [1:0] S_OFF = 2'h0;
  localparam [1:0] S_SLEEP = 2'h1;
  localparam [1:0] S_SETTLE = 2'h2;
  localparam [1:0] S_CAL = 2'h3;

  // Registers
  reg [7:0] pin_cfg_r;
  reg [7:0] soft_trig_r;
  reg [7:0] lp_cfg_r;
  reg [7:0] vec_en_r;
  // Bus state
  reg [11:0] aw_addr_r;
  reg aw_got_r;
  reg [7:0] w_data_r;
  reg w_strb0_r;
  reg w_got_r;
  // Trigger synchroniser
  reg pin_meta_r;
  reg pin_sync_r;
  // Scheduler
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg tmr_start_r;
  reg tmr_start_nxt;
  reg [5:0] tmr_exp_r;
  reg [5:0] tmr_exp_nxt;
  reg cal_start_nxt;
  wire tmr_busy;
  wire tmr_done;
  wire trig_sel;
  wire lp_on;
  wire do_write;

  // =====================================================================
  // Delay exponent decode and simulation shortening
  function [5:0] sleep_exp;
    input [2:0] code;
    begin
      case (code)
        3'h0: sleep_exp = `CTLP_SLEEP_K0;
        3'h1: sleep_exp = `CTLP_SLEEP_K1;
        3'h2: sleep_exp = `CTLP_SLEEP_K2;
        3'h3: sleep_exp = `CTLP_SLEEP_K3;
        3'h4: sleep_exp = `CTLP_SLEEP_K4;
        3'h5: sleep_exp = `CTLP_SLEEP_K5;
        3'h6: sleep_exp = `CTLP_SLEEP_K6;
        default: sleep_exp = `CTLP_SLEEP_K7;
      endcase
    end
  endfunction

  function [5:0] wake_exp;
    input [1:0] code;
    begin
      case (code)
        2'h0: wake_exp = `CTLP_WAKE_K0;
        2'h1: wake_exp = `CTLP_WAKE_K1;
        2'h2: wake_exp = `CTLP_WAKE_K2;
        default: wake_exp = `CTLP_WAKE_K3;
      endcase
    end
  endfunction

  function [5:0] eff_exp;
    input [5:0] k;
    begin
      if (k > EXP_REDUCE) begin
        eff_exp = k - EXP_REDUCE;
      end else begin
        eff_exp = 6'h00;
      end
    end
  endfunction

  // Register read mux shared by the read channel
  function [31:0] read_word;
    input [11:0] addr;
    input [7:0] pin_cfg;
    input [7:0] soft_trig;
    input [7:0] lp_cfg;
    input [7:0] vec_en;
    input [7:0] status;
    begin
      case (addr)
        `CTLP_ADDR_PIN_CFG: read_word = {24'h000000, pin_cfg};
        `CTLP_ADDR_SOFT_TRIG: read_word = {24'h000000, soft_trig};
        `CTLP_ADDR_LP_CFG: read_word = {24'h000000, lp_cfg};
        `CTLP_ADDR_VEC_EN: read_word = {24'h000000, vec_en};
        `CTLP_ADDR_STATUS: read_word = {24'h000000, status};
        default: read_word = 32'h00000000;
      endcase
    end
  endfunction

  function addr_ok;
    input [11:0] addr;
    begin
      case (addr)
        `CTLP_ADDR_PIN_CFG, `CTLP_ADDR_SOFT_TRIG, `CTLP_ADDR_LP_CFG,
        `CTLP_ADDR_VEC_EN, `CTLP_ADDR_STATUS: addr_ok = 1'b1;
        default: addr_ok = 1'b0;
      endcase
    end
  endfunction

  // =====================================================================
  // AXI4-Lite write path: address and data taken in either order
  assign do_write = aw_got_r && w_got_r && !s_axi_bvalid_out;

  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out <= 1'b1;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= `CTLP_RESP_OKAY;
      aw_addr_r <= 12'h000;
      aw_got_r <= 1'b0;
      w_data_r <= 8'h00;
      w_strb0_r <= 1'b0;
      w_got_r <= 1'b0;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_addr_r <= s_axi_awaddr_in;
        aw_got_r <= 1'b1;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_data_r <= s_axi_wdata_in[7:0];
        w_strb0_r <= s_axi_wstrb_in[0];
        w_got_r <= 1'b1;
        s_axi_wready_out <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= addr_ok(aw_addr_r) ? `CTLP_RESP_OKAY : `CTLP_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out <= 1'b1;
      end
    end
  end

  // =====================================================================
  // Register file; only byte lane 0 carries data
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_cfg_r <= `CTLP_RST_PIN_CFG;
      // R12: soft trigger starts high
      soft_trig_r <= `CTLP_RST_SOFT_TRIG;
      // R11: sleep code 4, wake code 1
      lp_cfg_r <= `CTLP_RST_LP_CFG;
      vec_en_r <= `CTLP_RST_VEC_EN;
    end else if (do_write && w_strb0_r) begin
      case (aw_addr_r)
        `CTLP_ADDR_PIN_CFG: pin_cfg_r <= w_data_r;
        `CTLP_ADDR_SOFT_TRIG: soft_trig_r <= w_data_r;
        `CTLP_ADDR_LP_CFG: lp_cfg_r <= w_data_r;
        `CTLP_ADDR_VEC_EN: vec_en_r <= w_data_r;
        default: pin_cfg_r <= pin_cfg_r;
      endcase
    end
  end

  // =====================================================================
  // AXI4-Lite read path: data one cycle after the address is taken
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h00000000;
      s_axi_rresp_out <= `CTLP_RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rdata_out <= read_word(s_axi_araddr_in, pin_cfg_r, soft_trig_r, lp_cfg_r,
          vec_en_r, {3'h0, adc_wake_out, cal_trigger_out, tmr_busy, state_r});
        s_axi_rresp_out <= addr_ok(s_axi_araddr_in) ? `CTLP_RESP_OKAY : `CTLP_RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end

  // =====================================================================
  // R15: two-stage trigger pin synchroniser
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pin_meta_r <= 1'b1;
      pin_sync_r <= 1'b1;
    end else begin
      pin_meta_r <= cal_trigger_pin_in;
      pin_sync_r <= pin_meta_r;
    end
  end

  // R01: soft bit when select clear
  // R02: synchronised pin when select set
  assign trig_sel = pin_cfg_r[`CTLP_BIT_TRIG_SEL] ? pin_sync_r
    : soft_trig_r[`CTLP_BIT_SOFT_TRIG];
  // R10: needs low-power and background enables
  assign lp_on = lp_cfg_r[`CTLP_BIT_LOW_POWER_CAL_ENABLE] && pin_cfg_r[`CTLP_BIT_BG_EN];

  // =====================================================================
  // Sleep/wake scheduler next state
  always @* begin
    state_nxt = state_r;
    tmr_start_nxt = 1'b0;
    tmr_exp_nxt = tmr_exp_r;
    cal_start_nxt = 1'b0;
    case (state_r)
      S_OFF: begin
        if (lp_on) begin
          state_nxt = S_SLEEP;
        end
      end
      S_SLEEP: begin
        if (!lp_on) begin
          state_nxt = S_OFF;
        end else if (lp_cfg_r[`CTLP_BIT_TRIG_MODE]) begin
          // R09: wake on trigger low
          if (!trig_sel) begin
            state_nxt = S_SETTLE;
            tmr_start_nxt = 1'b1;
            tmr_exp_nxt = eff_exp(wake_exp(lp_cfg_r[`CTLP_WAKE_HI:`CTLP_WAKE_LO]));
          end
        end else if (tmr_done) begin
          // R08: autonomous sleep expired
          state_nxt = S_SETTLE;
          tmr_start_nxt = 1'b1;
          tmr_exp_nxt = eff_exp(wake_exp(lp_cfg_r[`CTLP_WAKE_HI:`CTLP_WAKE_LO]));
        end else if (!tmr_busy && !tmr_start_r) begin
          // R04: time sleep from code
          tmr_start_nxt = 1'b1;
          tmr_exp_nxt = eff_exp(sleep_exp(lp_cfg_r[`CTLP_SLEEP_HI:`CTLP_SLEEP_LO]));
        end
      end
      S_SETTLE: begin
        if (!lp_on) begin
          state_nxt = S_OFF;
        end else if (tmr_done && !tmr_start_r) begin
          // R06: settle done, calibrate; a stale sleep done is ignored
          state_nxt = S_CAL;
          cal_start_nxt = 1'b1;
        end
      end
      S_CAL: begin
        if (!lp_on) begin
          state_nxt = S_OFF;
        end else if (cal_done_in) begin
          state_nxt = S_SLEEP;
        end
      end
      default: begin
        state_nxt = S_OFF;
      end
    endcase
  end

  // Scheduler registers and outputs
  always @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= S_OFF;
      tmr_start_r <= 1'b0;
      tmr_exp_r <= 6'h00;
      cal_start_out <= 1'b0;
      adc_wake_out <= 1'b1;
      lp_active_out <= 1'b0;
      cal_trigger_out <= 1'b1;
      background_cal_enable_out <= 1'b0;
      cal_vector_enable_out <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_start_r <= tmr_start_nxt;
      tmr_exp_r <= tmr_exp_nxt;
      cal_start_out <= cal_start_nxt;
      adc_wake_out <= (state_nxt != S_SLEEP);
      lp_active_out <= (state_nxt != S_OFF);
      cal_trigger_out <= trig_sel;
      background_cal_enable_out <= pin_cfg_r[`CTLP_BIT_BG_EN];
      // R13: vector port enable
      cal_vector_enable_out <= vec_en_r[`CTLP_BIT_VEC_EN];
    end
  end

  // =====================================================================
  // Shared sleep and settle timer
  ctlp_delay_timer #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_timer (
    .core_clk_in(core_clk_in),
    .rst_n_in(rst_n_in),
    .start_in(tmr_start_r),
    .abort_in(state_r == S_OFF),
    .exp_in(tmr_exp_r),
    .busy_out(tmr_busy),
    .done_out(tmr_done)
  );

endmodule

// ### shared/ctlp_consts.vh
// Constants for the calibration trigger and low-power control block
`ifndef CTLP_CONSTS_VH
`define CTLP_CONSTS_VH

// =====================================================================
// Register indices and AXI4-Lite byte addresses (byte address = 4 x index)
`define CTLP_IDX_PIN_CFG 8'h6B
`define CTLP_IDX_SOFT_TRIG 8'h6C
`define CTLP_IDX_LP_CFG 8'h6E
`define CTLP_IDX_VEC_EN 8'h70
`define CTLP_IDX_STATUS 8'h72
`define CTLP_ADDR_PIN_CFG 12'h1AC
`define CTLP_ADDR_SOFT_TRIG 12'h1B0
`define CTLP_ADDR_LP_CFG 12'h1B8
`define CTLP_ADDR_VEC_EN 12'h1C0
`define CTLP_ADDR_STATUS 12'h1C8

// =====================================================================
// Reset values
`define CTLP_RST_PIN_CFG 8'h00
`define CTLP_RST_SOFT_TRIG 8'h01
`define CTLP_RST_LP_CFG 8'h88
`define CTLP_RST_VEC_EN 8'h00

// =====================================================================
// Field positions
`define CTLP_BIT_TRIG_SEL 0
`define CTLP_BIT_BG_EN 3
`define CTLP_BIT_SOFT_TRIG 0
`define CTLP_BIT_LOW_POWER_CAL_ENABLE 0
`define CTLP_BIT_TRIG_MODE 1
`define CTLP_WAKE_HI 4
`define CTLP_WAKE_LO 3
`define CTLP_SLEEP_HI 7
`define CTLP_SLEEP_LO 5
`define CTLP_BIT_VEC_EN 0

// =====================================================================
// Delay exponents k, delay = (2^k + 1) x 256 clock periods
`define CTLP_TICK_CYCLES 256
`define CTLP_SLEEP_K0 6'h03
`define CTLP_SLEEP_K1 6'h0F
`define CTLP_SLEEP_K2 6'h12
`define CTLP_SLEEP_K3 6'h15
`define CTLP_SLEEP_K4 6'h18
`define CTLP_SLEEP_K5 6'h1B
`define CTLP_SLEEP_K6 6'h1E
`define CTLP_SLEEP_K7 6'h21
`define CTLP_WAKE_K0 6'h21
`define CTLP_WAKE_K1 6'h12
`define CTLP_WAKE_K2 6'h15
`define CTLP_WAKE_K3 6'h18

// =====================================================================
// AXI responses
`define CTLP_RESP_OKAY 2'h0
`define CTLP_RESP_SLVERR 2'h2

`endif
